// File: ssw_host_model.sv
// Host microcontroller model that sends control frames on the serial pins.
`timescale 1ns/1ns
`default_nettype none

module ssw_host_model (
	output var logic sclk_pin,
	output var logic mosi_pin,
	output var logic select_in_n
);
	// ------------------------------------------------------------------------
	// Idle pins
	// ------------------------------------------------------------------------
	// Select idles high and the link clock stands low between frames.
	initial begin
		sclk_pin    = 1'h0;
		mosi_pin    = 1'h0;
		select_in_n = 1'h1;
	end

	// Sends one frame MSB first; the odd start offset keeps the link out of phase with clk.
	task automatic send(input logic [15:0] word);
		#7;
		select_in_n = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			mosi_pin = word[i];
			#160 sclk_pin = 1'h1;
			#160 sclk_pin = 1'h0;
		end
		#160 select_in_n = 1'h1;
		// The released line must not keep showing the last bit, so it shows the inverse.
		mosi_pin = ~word[0];
	endtask : send
endmodule : ssw_host_model
`default_nettype wire

// File: ssw_map.svh
// Constants for the software watchdog supervisor: field positions, timings, limits.
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and tick timing
// ----------------------------------------------------------------------------
`define SSW_CLK_NS       40
`define SSW_TICK_NS      1000000
`define SSW_CS_DELAY     3
`define SSW_FRAME_BITS   16

// ----------------------------------------------------------------------------
// Watchdog timings in milliseconds, window limits in percent of the period
// ----------------------------------------------------------------------------
`define SSW_LONG_WIN_MS  16'h00C8
`define SSW_RD1_MS       16'h000A
`define SSW_RD2_MS       16'h0002
`define SSW_CLOSED_PCT   8'h3C
`define SSW_EXPIRE_PCT   8'h8C
`define SSW_PER_MS_0     16'h000A
`define SSW_PER_MS_1     16'h0014
`define SSW_PER_MS_2     16'h0032
`define SSW_PER_MS_3     16'h0064
`define SSW_PER_MS_4     16'h00C8
`define SSW_PER_MS_5     16'h01F4
`define SSW_PER_MS_6     16'h03E8
`define SSW_PER_MS_7     16'h2710

// ----------------------------------------------------------------------------
// Control register frame layout and reset values
// ----------------------------------------------------------------------------
`define SSW_CTRL_ADDR    7'h15
`define SSW_WIN_BIT      5
`define SSW_PER_MSB      2
`define SSW_PER_LSB      0
`define SSW_CFG2_CODE    2'h1
`define SSW_FAIL_MAX_C2  2'h1
`define SSW_FAIL_MAX     2'h2
`define SSW_WIN_RST      1'h0
`define SSW_PER_RST      3'h0

`endif

// File: ssw_pkg.sv
// Types shared by the software watchdog supervisor modules.
package ssw_pkg;

	typedef enum logic [2:0] {
		SSW_INIT, SSW_NORMAL, SSW_STOP, SSW_SLEEP, SSW_RESTART, SSW_FAILSAFE
	} ssw_chip_e;

	typedef enum logic [1:0] {ST_OFF, ST_LONG, ST_RUN, ST_HOLD} ssw_state_e;

	typedef logic [15:0] ssw_ms_t;

	typedef struct packed {
		logic [7:0] data;
		logic       wr;
		logic [6:0] addr;
	} ssw_frame_s;

	typedef struct packed {
		logic       win;
		logic [2:0] per;
	} ssw_cfg_s;

endpackage : ssw_pkg

// File: ssw_serial_rx.sv
// Serial frame receiver: pin synchronisers, shifter and select-release delay.
`timescale 1ns/1ns
`default_nettype none
`include "ssw_map.svh"

module ssw_serial_rx (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          sclk_pin,
	input  wire logic          mosi_pin,
	input  wire logic          select_in_n,
	output logic               frame_valid,
	output ssw_pkg::ssw_frame_s frame
);
	import ssw_pkg::*;

	logic [2:0]  sclk_m;
	logic [1:0]  mosi_m;
	logic [2:0]  sel_m;
	logic [15:0] shift_r;
	logic [4:0]  bits_r;
	logic [1:0]  dly_r;
	logic        sclk_rise;
	logic        sel_rise;
	logic        sel_fall;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// Two flops per pin; the third stage only feeds the edge detectors.
	always_ff @(posedge clk) begin
		sclk_m <= {sclk_m[1:0], sclk_pin};
		mosi_m <= {mosi_m[0], mosi_pin};
		sel_m  <= {sel_m[1:0], select_in_n};
	end

	assign sclk_rise = sclk_m[1] & ~sclk_m[2];
	assign sel_rise  = sel_m[1] & ~sel_m[2];
	assign sel_fall  = ~sel_m[1] & sel_m[2];

	// ------------------------------------------------------------------------
	// Shifter
	// ------------------------------------------------------------------------
	// Bits arrive most significant first; the count saturates so that long
	// frames are rejected instead of wrapping into a false match.
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_r <= 16'h0000;
			bits_r  <= 5'h00;
		end else if (sel_fall) begin
			bits_r <= 5'h00;
		end else if (sclk_rise && !sel_m[1]) begin
			shift_r <= {shift_r[14:0], mosi_m[1]};
			if (bits_r != 5'h1F)
				bits_r <= bits_r + 5'h01;
		end
	end

	// ------------------------------------------------------------------------
	// Interpretation delay
	// ------------------------------------------------------------------------
	// Only a frame of exactly sixteen bits is handed on, a fixed number of
	// cycles after the select line is released.
	always_ff @(posedge clk) begin
		if (rst) begin
			dly_r       <= 2'h0;
			frame_valid <= 1'b0;
			frame       <= '0;
		end else begin
			frame_valid <= (dly_r == 2'h1);
			if (dly_r != 2'h0)
				dly_r <= dly_r - 2'h1;
			if (sel_rise && bits_r == 5'(`SSW_FRAME_BITS)) begin
				dly_r <= 2'(`SSW_CS_DELAY - 1); // R06
				frame <= shift_r;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sel_to_valid_a: assert property (sel_rise && bits_r == 5'h10 |-> ##3 frame_valid) // R06
		else $error("frame not delivered three cycles after select release");

endmodule : ssw_serial_rx
`default_nettype wire

// File: ssw_watchdog.sv
// Software watchdog supervisor: service check, window timing and reset output.
//
// Functional notes
// R01: Time-out or window watchdog by window select bit; time-out after reset.
// R02: Type and timing are set only in Normal mode; kept unchanged in Stop.
// R03: In Init the watchdog starts a long open window after reset release.
// R04: Off in Sleep and Restart; long open window on the next Normal entry.
// R05: Writing the control register restarts the timer with the new setting.
// R06: A service is acted on three cycles after the select line rises.
// R07: After Init or Restart a 200 ms long open window accepts any service.
// R08: Eight periods from 10 ms to 10000 ms, shared by both types.
// R09: A failure requests Restart or Fail-Safe and updates the failure count.
// R10: On reset release after a failure, long open window and Normal entry.
// R11: In Development mode the watchdog is off and never resets.
// R12: Failure count increments on a closed-window service or an expiry.
// R13: Failure count saturates at 01 for configuration 2, else at 10.
// R14: Count clears on good service, Stop disable, Sleep, non-watchdog Fail-Safe.
// R15: Time-out mode accepts a service anywhere and starts a new period.
// R16: Time-out expiry drives reset low and requests Restart or Fail-Safe.
// R17: Window mode period is closed then open; service starts a new closed one.
// R18: Closed window is 60 percent; the period marks the open window middle.
// R19: The host services between 0.72 and 1.20 periods after the last one.
// R20: Closed-window service or window expiry drives reset low and fails.
// R21: The eight data bits including the check bit must have even parity.
// R22: A parity error ignores the write and sets the serial failure flag.
// R23: Reserved data bit 3 takes part in the parity even though unread.
// R24: Reset stays low for the extended delay, or reduced when selected.
// R25: Windows are counted in oscillator ticks; changes apply at next restart.
`timescale 1ns/1ns
`default_nettype none
`include "ssw_map.svh"

module ssw_watchdog #(
	parameter int unsigned TICK_CYC = `SSW_TICK_NS / `SSW_CLK_NS
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              sclk_pin,
	input  wire logic              mosi_pin,
	input  wire logic              select_in_n,
	input  wire ssw_pkg::ssw_chip_e chip_mode,
	input  wire logic              dev_mode,
	input  wire logic              stop_wd_off,
	input  wire logic              fail_to_failsafe,
	input  wire logic [1:0]        safety_config,
	input  wire logic              reset_delay_select,
	input  wire logic              serial_fail_clr,
	output logic                   reset_out_n,
	output logic                   restart_req,
	output logic                   failsafe_req,
	output logic                   normal_req,
	output logic [1:0]             service_failure_count,
	output logic                   serial_fail,
	output logic                   window_mode_select,
	output logic [2:0]             period_select_field
);
	import ssw_pkg::*;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic ssw_ms_t ssw_period_ms(input logic [2:0] sel);
		ssw_ms_t ms;
		unique case (sel)
			3'h0: ms = `SSW_PER_MS_0;
			3'h1: ms = `SSW_PER_MS_1;
			3'h2: ms = `SSW_PER_MS_2;
			3'h3: ms = `SSW_PER_MS_3;
			3'h4: ms = `SSW_PER_MS_4;
			3'h5: ms = `SSW_PER_MS_5;
			3'h6: ms = `SSW_PER_MS_6;
			3'h7: ms = `SSW_PER_MS_7;
		endcase
		return ms;
	endfunction : ssw_period_ms

	function automatic ssw_ms_t ssw_scale(input ssw_ms_t ms, input logic [7:0] pct);
		logic [23:0] p;
		p = 24'(ms) * 24'(pct);
		return 16'(p / 24'h000064);
	endfunction : ssw_scale

	ssw_frame_s  frame;
	logic        frame_valid;
	ssw_state_e  state_r;
	ssw_state_e  state_nxt;
	ssw_cfg_s    cfg_r;
	ssw_cfg_s    cfg_nxt;
	ssw_cfg_s    act_cfg_r;
	logic [31:0] tick_cnt_r;
	ssw_ms_t     elapsed_r;
	ssw_ms_t     per_ms;
	ssw_ms_t     closed_ms;
	ssw_ms_t     limit;
	logic        wd_cause_r;
	logic        tick;
	logic        live;
	logic        go_off;
	logic        ctrl_wr;
	logic        svc;
	logic        svc_bad;
	logic        early;
	logic        expired;
	logic        fail;
	logic        good;
	logic        restart;
	logic        cnt_clr;
	logic [1:0]  fail_max;

	ssw_serial_rx u_rx (
		.clk         (clk),
		.rst         (rst),
		.sclk_pin    (sclk_pin),
		.mosi_pin    (mosi_pin),
		.select_in_n (select_in_n),
		.frame_valid (frame_valid),
		.frame       (frame)
	);

	// ------------------------------------------------------------------------
	// Service decode
	// ------------------------------------------------------------------------
	// Parity is taken over the written byte as sent, reserved bit included.
	assign ctrl_wr = frame_valid && frame.wr && frame.addr == `SSW_CTRL_ADDR;
	assign svc     = ctrl_wr && ~^frame.data; // R21 R23
	assign svc_bad = ctrl_wr && ^frame.data; // R22

	// ------------------------------------------------------------------------
	// Window arithmetic
	// ------------------------------------------------------------------------
	// The window mode expires at 140 percent so the period sits in the middle
	// of the open window; a host inside 0.72 to 1.20 periods always passes.
	always_comb begin
		per_ms    = ssw_period_ms(act_cfg_r.per); // R08
		closed_ms = ssw_scale(per_ms, `SSW_CLOSED_PCT); // R18
		unique case (state_r)
			ST_LONG: limit = `SSW_LONG_WIN_MS; // R07
			ST_HOLD: limit = reset_delay_select ? `SSW_RD2_MS : `SSW_RD1_MS; // R24
			default: limit = act_cfg_r.win ? ssw_scale(per_ms, `SSW_EXPIRE_PCT) : per_ms; // R19
		endcase
	end

	// ------------------------------------------------------------------------
	// Event decisions
	// ------------------------------------------------------------------------
	// Switching off has priority over failing, failing over a good service.
	assign live    = state_r == ST_LONG || state_r == ST_RUN;
	assign go_off  = live && (dev_mode || chip_mode == SSW_SLEEP || // R11
	                 chip_mode == SSW_RESTART || chip_mode == SSW_FAILSAFE || // R04
	                 (chip_mode == SSW_STOP && stop_wd_off));
	assign early   = state_r == ST_RUN && act_cfg_r.win && elapsed_r < closed_ms; // R17
	assign expired = live && elapsed_r >= limit; // R16
	assign fail    = live && !go_off && (expired || (svc && early)); // R20
	assign good    = live && !go_off && !fail && svc; // R15
	assign restart = state_nxt != state_r || good; // R05

	// ------------------------------------------------------------------------
	// State selection
	// ------------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_OFF: begin
				if (!dev_mode && chip_mode == SSW_NORMAL)
					state_nxt = ST_LONG; // R04
			end
			ST_HOLD: begin
				if (elapsed_r >= limit)
					state_nxt = ST_LONG; // R03 R10
			end
			ST_LONG, ST_RUN: begin
				if (go_off)
					state_nxt = ST_OFF;
				else if (fail)
					state_nxt = ST_HOLD; // R09
				else if (good)
					state_nxt = ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------------------
	// Settings are only taken in Normal mode, so Stop keeps what was there.
	always_comb begin
		cfg_nxt = cfg_r;
		if (svc && chip_mode == SSW_NORMAL) begin // R02
			cfg_nxt.win = frame.data[`SSW_WIN_BIT]; // R01
			cfg_nxt.per = frame.data[`SSW_PER_MSB:`SSW_PER_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_r     <= {`SSW_WIN_RST, `SSW_PER_RST}; // R01
			act_cfg_r <= {`SSW_WIN_RST, `SSW_PER_RST};
		end else begin
			cfg_r <= cfg_nxt;
			if (restart)
				act_cfg_r <= cfg_nxt; // R25
		end
	end

	// ------------------------------------------------------------------------
	// Tick timer
	// ------------------------------------------------------------------------
	// The prescaler restarts with the window so that every window starts on
	// a whole tick; the cost is up to one tick of jitter on the previous one.
	assign tick = tick_cnt_r == 32'(TICK_CYC - 1);

	always_ff @(posedge clk) begin
		if (rst || restart) begin
			tick_cnt_r <= 32'h00000000;
			elapsed_r  <= 16'h0000;
		end else if (tick) begin
			tick_cnt_r <= 32'h00000000;
			if (elapsed_r != 16'hFFFF)
				elapsed_r <= elapsed_r + 16'h0001; // R25
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			state_r <= ST_HOLD;
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------------------
	// Reset output and mode requests
	// ------------------------------------------------------------------------
	// The failure cause is kept through the hold, because the mode logic answers a
	// request a cycle late and would otherwise clear it before the release.
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_out_n  <= 1'b0;
			restart_req  <= 1'b0;
			failsafe_req <= 1'b0;
			normal_req   <= 1'b0;
			wd_cause_r   <= 1'b0;
		end else begin
			reset_out_n  <= state_nxt != ST_HOLD; // R16 R20
			restart_req  <= fail && !fail_to_failsafe; // R09
			failsafe_req <= fail && fail_to_failsafe;
			normal_req   <= state_r == ST_HOLD && state_nxt == ST_LONG && wd_cause_r; // R10
			if (fail)
				wd_cause_r <= 1'b1;
			else if (chip_mode == SSW_NORMAL && state_r != ST_HOLD)
				wd_cause_r <= 1'b0; // R10
		end
	end

	// ------------------------------------------------------------------------
	// Failure counter
	// ------------------------------------------------------------------------
	assign fail_max = safety_config == `SSW_CFG2_CODE ? `SSW_FAIL_MAX_C2 : `SSW_FAIL_MAX;
	assign cnt_clr  = good || (state_r == ST_OFF && (chip_mode == SSW_SLEEP ||
	                  (chip_mode == SSW_STOP && stop_wd_off) ||
	                  (chip_mode == SSW_FAILSAFE && !wd_cause_r))); // R14

	always_ff @(posedge clk) begin
		if (rst)
			service_failure_count <= 2'h0;
		else if (fail)
			service_failure_count <= service_failure_count < fail_max ?
				service_failure_count + 2'h1 : fail_max; // R12 R13
		else if (cnt_clr)
			service_failure_count <= 2'h0;
	end

	// A parity error in the same cycle as a clear still leaves the flag set.
	always_ff @(posedge clk) begin
		if (rst)
			serial_fail <= 1'b0;
		else if (svc_bad)
			serial_fail <= 1'b1; // R22
		else if (serial_fail_clr)
			serial_fail <= 1'b0;
	end

	assign window_mode_select  = cfg_r.win;
	assign period_select_field = cfg_r.per;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	fail_reset_low_a: assert property (fail |=> !reset_out_n && state_r == ST_HOLD) // R16
		else $error("failure did not pull reset low");
	early_service_a: assert property (svc && early && !go_off |=> !reset_out_n) // R20
		else $error("closed window service not punished");
	count_step_a: assert property (fail && service_failure_count == 2'h0 |=> // R12
		service_failure_count == 2'h1)
		else $error("failure count did not step");
	count_sat_a: assert property (safety_config == 2'h1 && fail |=> // R13
		service_failure_count <= 2'h1)
		else $error("failure count passed limit");
	count_clear_a: assert property (good |=> service_failure_count == 2'h0) // R14
		else $error("good service did not clear count");
	parity_ignore_a: assert property (svc_bad |=> serial_fail && // R22
		$stable(period_select_field) && $stable(window_mode_select))
		else $error("bad parity write took effect");
	stop_cfg_hold_a: assert property (chip_mode == SSW_STOP |=> // R02
		$stable(period_select_field) && $stable(window_mode_select))
		else $error("setting changed in stop");
	dev_off_a: assert property (dev_mode && live |=> state_r == ST_OFF && !restart_req) // R11
		else $error("watchdog active in development mode");
	release_long_a: assert property (state_r == ST_HOLD && state_nxt == ST_LONG |=> // R10
		reset_out_n && state_r == ST_LONG && elapsed_r == 16'h0000)
		else $error("no long window after reset release");
	sleep_off_a: assert property (live && chip_mode == SSW_SLEEP |=> state_r == ST_OFF) // R04
		else $error("watchdog running in sleep");

endmodule : ssw_watchdog
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the software watchdog supervisor.
`timescale 1ns/1ns
`default_nettype none
`include "ssw_map.svh"

module tb_top;
	import ssw_pkg::*;

	logic       clk, rst, sclk_pin, mosi_pin, select_in_n, dev_mode, fail_to_failsafe;
	logic       reset_delay_select, serial_fail_clr, reset_out_n, restart_req, failsafe_req;
	logic       normal_req, serial_fail, window_mode_select, stop_wd_off;
	logic [1:0] safety_config, service_failure_count;
	logic [2:0] period_select_field;
	ssw_chip_e  chip_mode;
	int         failures, checked, n_rs, n_fs, n_nm, cyc, n;

	ssw_host_model ssw_host_model_inst (.sclk_pin(sclk_pin), .mosi_pin(mosi_pin),
		.select_in_n(select_in_n));

	ssw_watchdog #(.TICK_CYC(16)) ssw_watchdog_inst (.clk(clk), .rst(rst),
		.sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .select_in_n(select_in_n),
		.chip_mode(chip_mode), .dev_mode(dev_mode), .stop_wd_off(stop_wd_off),
		.fail_to_failsafe(fail_to_failsafe), .safety_config(safety_config),
		.reset_delay_select(reset_delay_select), .serial_fail_clr(serial_fail_clr),
		.reset_out_n(reset_out_n), .restart_req(restart_req), .failsafe_req(failsafe_req),
		.normal_req(normal_req), .service_failure_count(service_failure_count),
		.serial_fail(serial_fail), .window_mode_select(window_mode_select),
		.period_select_field(period_select_field));

	// ------------------------------------------------------------------------
	// Clock, hang guard and mode logic stand-in
	// ------------------------------------------------------------------------
	// One tick is 16 cycles, so every expected window below is ticks times 16.
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// The mode logic follows the supervisor's requests as the rest of the chip would.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			failures++;
			final_report();
		end
		if (restart_req === 1'h1) begin
			n_rs <= n_rs + 1;
			chip_mode <= SSW_RESTART;
		end
		if (failsafe_req === 1'h1) begin
			n_fs <= n_fs + 1;
			chip_mode <= SSW_FAILSAFE;
		end
		if (normal_req === 1'h1) begin
			n_nm <= n_nm + 1;
			chip_mode <= SSW_NORMAL;
		end
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Compares and counts.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Checks that a measured count of cycles lies in a window.
	task automatic rng(input int v, input int lo, input int hi);
		chk(32'(v >= lo && v <= hi), 32'h1);
	endtask : rng

	// Counts cycles until the reset output reaches a level, bounded.
	task automatic wt(input logic lvl);
		n = 0;
		while (reset_out_n !== lvl && n < 5000) begin
			@(negedge clk);
			n++;
		end
	endtask : wt

	// Builds a control write; the check bit makes the data byte even unless bad is set.
	function automatic logic [15:0] frm(input logic w, input logic [2:0] p, input logic r,
		input logic bad);
		logic [6:0] d;
		d = {1'h0, w, 1'h0, r, p};
		return {(^d) ^ bad, d, 1'h1, `SSW_CTRL_ADDR};
	endfunction : frm

	// Sends a frame and lets its effect land.
	task automatic tx(input logic [15:0] w);
		ssw_host_model_inst.send(w);
		repeat (8) @(negedge clk);
	endtask : tx

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	// Reset values, extended delay, unserviced long window, reduced delay.
	task automatic t_boot();
		chk(reset_out_n, 1'h0);
		chk({window_mode_select, period_select_field}, 4'h0);
		wt(1'h1);
		rng(n, 150, 175);
		wt(1'h0);
		rng(n, 3185, 3215);
		reset_delay_select = 1'h1;
		@(negedge clk);
		chk(n_rs, 1);
		chk(service_failure_count, 2'h1);
		wt(1'h1);
		rng(n, 25, 40);
		@(negedge clk);
		chk(n_nm, 1);
	endtask : t_boot

	// Every period code, then the shortest period runs out.
	task automatic t_periods();
		for (int p = 7; p >= 0; p--) begin
			tx(frm(1'h0, 3'(p), 1'h0, 1'h0));
			chk(period_select_field, p);
			chk(service_failure_count, 2'h0);
		end
		wt(1'h0);
		rng(n, 140, 175);
		wt(1'h1);
	endtask : t_periods

	// Services inside the period keep the supervisor quiet; Stop keeps the setting.
	task automatic t_timeout();
		tx(frm(1'h0, 3'h1, 1'h0, 1'h0));
		repeat (4) tx(frm(1'h0, 3'h1, 1'h0, 1'h0));
		chk(n_rs, 2);
		chip_mode = SSW_STOP;
		tx(frm(1'h1, 3'h5, 1'h0, 1'h0));
		chk(period_select_field, 3'h1);
		chip_mode = SSW_NORMAL;
	endtask : t_timeout

	// Service in the open window passes; a back-to-back one hits the closed window.
	task automatic t_window();
		fail_to_failsafe = 1'h1;
		tx(frm(1'h1, 3'h2, 1'h0, 1'h0));
		chk(window_mode_select, 1'h1);
		repeat (450) @(negedge clk);
		tx(frm(1'h1, 3'h2, 1'h0, 1'h0));
		chk(n_rs + n_fs, 2);
		tx(frm(1'h1, 3'h2, 1'h0, 1'h0));
		chk(n_fs, 1);
		chk(service_failure_count, 2'h1);
		wt(1'h1);
		fail_to_failsafe = 1'h0;
	endtask : t_window

	// Bad check bits are ignored and flagged; the reserved bit counts in the check.
	task automatic t_parity();
		tx(frm(1'h0, 3'h6, 1'h0, 1'h1));
		chk(n_nm, 3);
		chk(serial_fail, 1'h1);
		chk(period_select_field, 3'h2);
		serial_fail_clr = 1'h1;
		@(negedge clk);
		serial_fail_clr = 1'h0;
		chk(serial_fail, 1'h0);
		tx(frm(1'h0, 3'h6, 1'h1, 1'h1));
		chk({serial_fail, period_select_field}, 4'hA);
		tx(frm(1'h0, 3'h1, 1'h1, 1'h0));
		chk({window_mode_select, period_select_field}, 4'h1);
		chk(service_failure_count, 2'h0);
	endtask : t_parity

	// Repeated failures saturate the count at the level of the configuration.
	task automatic t_sat();
		for (int c = 1; c >= 0; c--) begin
			safety_config = 2'(c);
			repeat (3) begin
				wt(1'h0);
				wt(1'h1);
			end
			chk(service_failure_count, c ? 2'h1 : 2'h2);
		end
	endtask : t_sat

	// Development, Sleep and a disabled Stop switch the supervisor off; Normal restarts it.
	task automatic t_off();
		n = n_rs;
		dev_mode = 1'h1;
		repeat (4000) @(negedge clk);
		chk(reset_out_n, 1'h1);
		chk(n_rs, n);
		dev_mode = 1'h0;
		@(negedge clk);
		chip_mode = SSW_SLEEP;
		repeat (4000) @(negedge clk);
		chk({reset_out_n, service_failure_count}, 3'h4);
		chip_mode = SSW_NORMAL;
		wt(1'h0);
		rng(n, 3185, 3220);
		wt(1'h1);
		repeat (2) @(negedge clk);
		chip_mode = SSW_STOP;
		stop_wd_off = 1'h1;
		n = n_rs;
		repeat (3400) @(negedge clk);
		chk({reset_out_n, service_failure_count}, 3'h4);
		chk(n_rs, n);
	endtask : t_off

	// ------------------------------------------------------------------------
	// Closing
	// ------------------------------------------------------------------------
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// Main sequence.
	initial begin
		{failures, checked, n_rs, n_fs, n_nm, cyc} = '0;
		{rst, dev_mode, fail_to_failsafe, reset_delay_select, serial_fail_clr} = 5'h10;
		stop_wd_off = 1'h0;
		safety_config = 2'h0;
		chip_mode = SSW_INIT;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		t_boot();
		t_periods();
		t_timeout();
		t_window();
		t_parity();
		t_sat();
		t_off();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
